/* File: dv/ars_link_model.sv */
// Purpose: Far-side TDM audio source: link clock, frame sync and serial data.
// Assumes: Sync and data change while the link clock is low, MSB first.
// Notes: Clock stands still between bursts; data then shows the inverse of its last bit.
`timescale 1ns/1ns
module ars_link_model (
    output logic rx_link_clk,
    output logic rx_frame_sync,
    output logic rx_serial_data
);
    initial begin
        rx_link_clk = 1'b0;
        rx_frame_sync = 1'b0;
        rx_serial_data = 1'b1;
    end
    // A short burst with sync set models a frame cut off by an early sync
    task automatic send_word(input logic sync, input logic [15:0] w, input int nbits);
        // Keep link edges off the clk_sys sampling edge
        #5;
        for (int i = 0; i < nbits; i++) begin
            rx_frame_sync = sync && (i == 0);
            rx_serial_data = w[15-i];
            #80 rx_link_clk = 1'b1;
            #80 rx_link_clk = 1'b0;
        end
        rx_frame_sync = 1'b0;
        rx_serial_data = ~rx_serial_data;
    endtask
endmodule

/* File: dv/ars_rx_status_checker.sv */
// Purpose: Port-level assertions for the receive status block.
// Assumes: Zero-wait APB; status read data is a snapshot from the setup cycle.
// Notes: Flag state is internal, so checks lean on register read-back.
`timescale 1ns/1ns
module ars_rx_status_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_link_clk,
    input wire logic rx_frame_sync,
    input wire logic rx_serial_data,
    input wire logic rx_clock_fail_flag,
    input wire logic rx_dma_error_event,
    input wire logic rx_interrupt,
    input wire logic rx_dma_event
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic rd;
    logic mapped;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = paddr inside {8'h80, 8'h84, 8'h8C, 8'h90, 8'h94, 8'h98};
    a_no_wait: assert property (psel |-> pready) else $error("pready low");
    a_dma_pulse: assert property (rx_dma_event |=> !rx_dma_event) else $error("dma event too long");
    a_irq_masked: assert property (acc && pwrite && paddr == 8'h98 && pwdata[7:0] == 8'h00 |=> !rx_interrupt)
        else $error("interrupt with all enables off");
    a_stat_resv: assert property (rd && paddr == 8'h80 |-> prdata[31:9] == 23'h0 && !prdata[2])
        else $error("status reserved bits set");
    a_slot_legal: assert property (rd && paddr == 8'h84 |-> prdata[31:1] == 31'h0)
        else $error("slot count out of range");
    a_evt_resv: assert property (rd && paddr == 8'h8C |-> prdata[31:1] == 31'h0)
        else $error("event ctrl reserved bits set");
    a_err_sum: assert property (rd && paddr == 8'h80 |->
        prdata[8] == (prdata[0] | prdata[1] | prdata[7] | $past(rx_clock_fail_flag)))
        else $error("error summary mismatch");
    a_bad_addr: assert property (acc && !mapped |-> pslverr) else $error("unmapped without pslverr");
    a_good_addr: assert property (acc && mapped |-> !pslverr) else $error("mapped with pslverr");
endmodule
bind ars_rx_status ars_rx_status_checker u_chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_link_clk, .rx_frame_sync, .rx_serial_data, .rx_clock_fail_flag,
    .rx_dma_error_event, .rx_interrupt, .rx_dma_event);

/* File: dv/tb_ars_rx_status.sv */
// Purpose: Self-checking bench for the receive status block over APB and link.
// Assumes: Zero-wait APB slave; 2 slots of 16 bits per frame.
// Notes: DMA events are counted so waits end on the design's own completion.
`timescale 1ns/1ns
module tb_ars_rx_status;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, rx_interrupt, rx_dma_event, link_clk, fsync, sdata;
    logic clk_fail = 1'b0;
    logic dma_err = 1'b0;
    int bad_count = 0;
    int checks_done = 0;
    int dma_cnt = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rx_dma_event === 1'b1) dma_cnt <= dma_cnt + 1;
    ars_rx_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_link_clk(link_clk), .rx_frame_sync(fsync), .rx_serial_data(sdata), .rx_clock_fail_flag(clk_fail),
        .rx_dma_error_event(dma_err), .rx_interrupt(rx_interrupt), .rx_dma_event(rx_dma_event));
    ars_link_model u_link (.rx_link_clk(link_clk), .rx_frame_sync(fsync), .rx_serial_data(sdata));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Interrupt is combinational from registers, so look once the edge has settled
    task automatic chk_irq(input logic exp);
        @(negedge clk_sys);
        check({31'h0, rx_interrupt}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
    endtask
    // Bounded wait for the DMA event count to reach a target
    task automatic wait_dma(input int target);
        for (int i = 0; i < 100 && dma_cnt < target; i++) @(posedge clk_sys);
        check(dma_cnt, target);
        if (dma_cnt < target) begin
            wrap_up();
        end
    endtask
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        logic [7:0] ofs [6] = '{8'h80, 8'h84, 8'h8C, 8'h90, 8'h94, 8'h98};
        foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
        apb(1'b0, 8'h88, 32'h0000_0000, r, e);
        check({31'h0, e}, 32'h0000_0001);
        wr(8'h8C, 32'hFFFF_FFFE);
        rd(8'h8C, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_slots;
        wr(8'h98, 32'h0000_0020);
        u_link.send_word(1'b1, 16'hA5A5, 16);
        wait_dma(1);
        chk_irq(1'b1);
        rd(8'h80, 32'h0000_0068);
        rd(8'h84, 32'h0000_0001);
        rd(8'h90, 32'h0000_A5A5);
        u_link.send_word(1'b0, 16'h3C3C, 16);
        wait_dma(2);
        rd(8'h80, 32'h0000_0070);
        rd(8'h84, 32'h0000_0000);
        rd(8'h90, 32'h0000_3C3C);
        wr(8'h80, 32'h0000_0000);
        rd(8'h80, 32'h0000_0070);
        wr(8'h80, 32'h0000_0020);
        rd(8'h80, 32'h0000_0050);
        wr(8'h94, 32'h0000_0050);
        rd(8'h80, 32'h0000_0000);
        chk_irq(1'b0);
        $display("test slots done");
    endtask
    task automatic t_overrun;
        u_link.send_word(1'b1, 16'h1111, 16);
        u_link.send_word(1'b0, 16'h2222, 16);
        wait_dma(4);
        rd(8'h80, 32'h0000_0171);
        rd(8'h90, 32'h0000_2222);
        wr(8'h98, 32'h0000_0001);
        chk_irq(1'b1);
        wr(8'h98, 32'hFFFF_FFFF);
        rd(8'h98, 32'h0000_00F3);
        wr(8'h98, 32'h0000_0000);
        chk_irq(1'b0);
        wr(8'h94, 32'h0000_00F3);
        rd(8'h80, 32'h0000_0000);
        $display("test overrun done");
    endtask
    task automatic t_errors;
        @(posedge clk_sys) clk_fail <= 1'b1;
        rd(8'h80, 32'h0000_0100);
        @(posedge clk_sys) clk_fail <= 1'b0;
        dma_err <= 1'b1;
        @(posedge clk_sys) dma_err <= 1'b0;
        rd(8'h80, 32'h0000_0180);
        wr(8'h80, 32'h0000_0080);
        rd(8'h80, 32'h0000_0000);
        // DMA-error pulse lands on the same edge as the clearing write
        wr(8'h98, 32'h0000_0080);
        fork
            wr(8'h94, 32'h0000_0080);
            begin
                repeat (2) @(posedge clk_sys);
                dma_err <= 1'b1;
                @(posedge clk_sys);
                dma_err <= 1'b0;
            end
        join
        rd(8'h80, 32'h0000_0180);
        chk_irq(1'b1);
        wr(8'h80, 32'h0000_0080);
        wr(8'h98, 32'h0000_0000);
        rd(8'h80, 32'h0000_0000);
        $display("test errors done");
    endtask
    task automatic t_early;
        u_link.send_word(1'b1, 16'hFFFF, 8);
        u_link.send_word(1'b1, 16'h0F0F, 16);
        wait_dma(5);
        rd(8'h80, 32'h0000_016A);
        rd(8'h90, 32'h0000_0F0F);
        $display("test early sync done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_slots();
        t_overrun();
        t_errors();
        t_early();
        wrap_up();
    end
endmodule

/* File: rtl/ars_link_rx.sv */
// Purpose: Receive link front end: synchronises pins, finds clock edges, shifts slots.
// Assumes: Link clock well below clk_sys; data and sync sampled on the link rising edge.
// Notes: Sync is expected on the first bit after the last bit of the last slot.
`timescale 1ns/1ns
module ars_link_rx (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rx_link_clk,
    input wire logic rx_frame_sync,
    input wire logic rx_serial_data,
    output logic word_done,
    output logic [15:0] word_data,
    output logic word_last,
    output logic frame_start,
    output logic early_sync,
    output logic cur_slot
);
    logic [2:0] clk_sync_ff;
    logic [1:0] fs_sync_ff;
    logic [1:0] dat_sync_ff;
    logic link_rise;
    ars_pkg::ars_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic slot_ff;
    logic [15:0] shift_ff;
    logic done_ff;
    logic [15:0] word_ff;
    logic last_ff;
    logic sof_ff;
    logic early_ff;
    logic sync_expected;

    // Stage 0 of each chain feeds only stage 1
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_ff <= 3'b000;
            fs_sync_ff <= 2'b00;
            dat_sync_ff <= 2'b00;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], rx_link_clk};
            fs_sync_ff <= {fs_sync_ff[0], rx_frame_sync};
            dat_sync_ff <= {dat_sync_ff[0], rx_serial_data};
        end
    end

    assign link_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
    assign sync_expected = (bit_cnt_ff == 4'h0) && (slot_ff == 1'b0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ars_pkg::ARS_HUNT;
            bit_cnt_ff <= 4'h0;
            slot_ff <= 1'b0;
            shift_ff <= 16'h0000;
        end else if (link_rise) begin
            unique case (state_ff)
                ars_pkg::ARS_HUNT: begin
                    if (fs_sync_ff[1]) begin
                        state_ff <= ars_pkg::ARS_RUN;
                        bit_cnt_ff <= 4'h1;
                        slot_ff <= 1'b0;
                        shift_ff <= {15'h0000, dat_sync_ff[1]};
                    end
                end
                ars_pkg::ARS_RUN: begin
                    if (fs_sync_ff[1]) begin
                        // Any sync restarts the frame; a partial word is dropped
                        bit_cnt_ff <= 4'h1;
                        slot_ff <= 1'b0;
                        shift_ff <= {15'h0000, dat_sync_ff[1]};
                    end else if (bit_cnt_ff == ars_pkg::LAST_BIT_IDX) begin
                        bit_cnt_ff <= 4'h0;
                        slot_ff <= ~slot_ff;
                        shift_ff <= {shift_ff[14:0], dat_sync_ff[1]};
                    end else begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        shift_ff <= {shift_ff[14:0], dat_sync_ff[1]};
                    end
                end
            endcase
        end
    end

    // One-cycle event pulses toward the status logic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
            word_ff <= 16'h0000;
            last_ff <= 1'b0;
            sof_ff <= 1'b0;
            early_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            sof_ff <= 1'b0;
            early_ff <= 1'b0;
            if (link_rise && fs_sync_ff[1]) begin
                sof_ff <= 1'b1;
                early_ff <= (state_ff == ars_pkg::ARS_RUN) && !sync_expected;
            end else if (link_rise && state_ff == ars_pkg::ARS_RUN && bit_cnt_ff == ars_pkg::LAST_BIT_IDX) begin
                done_ff <= 1'b1;
                word_ff <= {shift_ff[14:0], dat_sync_ff[1]};
                last_ff <= (slot_ff == ars_pkg::LAST_SLOT_IDX);
            end
        end
    end

    assign word_done = done_ff;
    assign word_data = word_ff;
    assign word_last = last_ff;
    assign frame_start = sof_ff;
    assign early_sync = early_ff;
    assign cur_slot = slot_ff;
endmodule

/* File: rtl/ars_pkg.sv */
// Purpose: Constants for the receive status and event block of a TDM audio port.
// Assumes: APB slave with 32-bit data, clk_sys at 50 MHz, link sampled by clk_sys.
// Notes: Status flag layout is shared by the status, clear and enable registers.
// Function
// - Set data-ready flag whenever a received word moves into the receive buffer.
// - Each data-ready set issues a receive DMA event, whatever the interrupt enables, unless event control bit 0 is 1.
// - Interrupt is high while any enabled data, last, sync or overrun flag is set.
// - A status flag clears only on a written 1; a written 0 leaves it.
// - Last-slot flag sets together with data-ready when the word is the frame's last.
// - Slot-parity bit reads the LSB of the current slot count.
// - A frame sync arriving earlier than expected sets the early-sync flag.
// - Overrun sets when a word enters the buffer before the previous one was read.
// - Reserved bits of status, slot and event control registers read zero, ignore writes.
// - Slot count register reports the active slot in a 9-bit field, 0 or 1.
// - Hardware set wins over a same-cycle software clear; interrupt stays requested.
// - Error summary bit reads OR of overrun, early sync, clock-fail, DMA-error flags.
package ars_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h80;
    localparam logic [7:0] OFS_SLOT_COUNT = 8'h84;
    localparam logic [7:0] OFS_EVENT_CTRL = 8'h8C;
    localparam logic [7:0] OFS_BUFFER = 8'h90;
    localparam logic [7:0] OFS_CLEAR = 8'h94;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h98;

    // Status flag positions, then the event control bit
    localparam int BIT_OVERRUN = 0;
    localparam int BIT_EARLY_SYNC = 1;
    localparam int BIT_PARITY = 3;
    localparam int BIT_FINAL_SLOT = 4;
    localparam int BIT_DATA_READY = 5;
    localparam int BIT_START_FRAME = 6;
    localparam int BIT_DMA_ERROR = 7;
    localparam int BIT_ERROR_SUM = 8;
    localparam int BIT_DMA_REQ_CTRL = 0;

    localparam int FLAG_W = 8;
    localparam logic [7:0] FLAG_MASK = 8'hF3;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Link framing
    localparam int SLOT_BITS = 16;
    localparam int SLOT_COUNT_W = 9;
    localparam logic [3:0] LAST_BIT_IDX = 4'hF;
    localparam logic LAST_SLOT_IDX = 1'b1;

    typedef enum logic [1:0] {
        ARS_HUNT = 2'b01,
        ARS_RUN = 2'b10
    } ars_state_t;

endpackage

/* File: rtl/ars_rx_status.sv */
// Purpose: Receive status, slot report, buffer, interrupt and DMA event of a TDM port.
// Assumes: APB master keeps the request stable through the access phase.
// Notes: Zero wait states; unmapped addresses answer with pslverr.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module ars_rx_status (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_link_clk,
    input wire logic rx_frame_sync,
    input wire logic rx_serial_data,
    input wire logic rx_clock_fail_flag,
    input wire logic rx_dma_error_event,
    output logic rx_interrupt,
    output logic rx_dma_event
);
    logic word_done;
    logic [15:0] word_data;
    logic word_last;
    logic frame_start;
    logic early_sync;
    logic cur_slot;
    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] int_enable_ff;
    logic dma_req_ctrl_ff;
    logic [15:0] rx_buffer_ff;
    logic buf_full_ff;
    logic [31:0] prdata_ff;
    logic dma_event_ff;
    logic setup_phase;
    logic access_wr;
    logic access_rd;
    logic rx_error_summary;
    logic rx_slot_parity;
    logic [31:0] status_word;
    logic [31:0] slot_word;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, ars_pkg::OFS_STATUS) | hit(addr, ars_pkg::OFS_SLOT_COUNT)
               | hit(addr, ars_pkg::OFS_EVENT_CTRL) | hit(addr, ars_pkg::OFS_BUFFER)
               | hit(addr, ars_pkg::OFS_CLEAR) | hit(addr, ars_pkg::OFS_INT_ENABLE);
    endfunction

    ars_link_rx u_link (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rx_link_clk(rx_link_clk),
        .rx_frame_sync(rx_frame_sync),
        .rx_serial_data(rx_serial_data),
        .word_done(word_done),
        .word_data(word_data),
        .word_last(word_last),
        .frame_start(frame_start),
        .early_sync(early_sync),
        .cur_slot(cur_slot)
    );

    assign setup_phase = psel & ~penable;
    assign access_wr = psel & penable & pwrite & mapped(paddr);
    assign access_rd = psel & penable & ~pwrite & mapped(paddr);

    // Hardware events into the sticky bank
    always_comb begin
        flag_set = 8'h00;
        flag_set[ars_pkg::BIT_DATA_READY] = word_done;
        flag_set[ars_pkg::BIT_FINAL_SLOT] = word_done & word_last;
        // Buffer still unread when the next word lands
        flag_set[ars_pkg::BIT_OVERRUN] = word_done & buf_full_ff;
        flag_set[ars_pkg::BIT_EARLY_SYNC] = early_sync;
        flag_set[ars_pkg::BIT_START_FRAME] = frame_start;
        flag_set[ars_pkg::BIT_DMA_ERROR] = rx_dma_error_event;
    end

    // Clear by a 1 in the status register itself or in the clear register
    always_comb begin
        flag_clr = 8'h00;
        if (access_wr && (hit(paddr, ars_pkg::OFS_STATUS) || hit(paddr, ars_pkg::OFS_CLEAR))) begin
            flag_clr = pwdata[7:0] & ars_pkg::FLAG_MASK;
        end
    end

    ars_sticky #(
        .W(ars_pkg::FLAG_W)
    ) u_flags (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(flag_set),
        .clr(flag_clr),
        .q(flags)
    );

    assign rx_error_summary = flags[ars_pkg::BIT_OVERRUN] | flags[ars_pkg::BIT_EARLY_SYNC]
                            | rx_clock_fail_flag | flags[ars_pkg::BIT_DMA_ERROR];
    assign rx_slot_parity = cur_slot;

    always_comb begin
        status_word = ars_pkg::REG_RESET;
        status_word[7:0] = flags & ars_pkg::FLAG_MASK;
        status_word[ars_pkg::BIT_PARITY] = rx_slot_parity;
        status_word[ars_pkg::BIT_ERROR_SUM] = rx_error_summary;
    end

    always_comb begin
        slot_word = ars_pkg::REG_RESET;
        slot_word[ars_pkg::SLOT_COUNT_W-1:0] = {8'h00, cur_slot};
    end

    // Writable control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_enable_ff <= ars_pkg::FLAG_RESET;
        end else if (access_wr && hit(paddr, ars_pkg::OFS_INT_ENABLE)) begin
            int_enable_ff <= pwdata[7:0] & ars_pkg::FLAG_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_req_ctrl_ff <= 1'b0;
        end else if (access_wr && hit(paddr, ars_pkg::OFS_EVENT_CTRL)) begin
            // Reserved value 1 is stored but suppresses the DMA event
            dma_req_ctrl_ff <= pwdata[ars_pkg::BIT_DMA_REQ_CTRL];
        end
    end

    // Receive buffer; a read of it by CPU or DMA empties it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_ff <= 16'h0000;
            buf_full_ff <= 1'b0;
        end else if (word_done) begin
            rx_buffer_ff <= word_data;
            buf_full_ff <= 1'b1;
        end else if (access_rd && hit(paddr, ars_pkg::OFS_BUFFER)) begin
            buf_full_ff <= 1'b0;
        end
    end

    // DMA event pulses with every data-ready set while event control bit 0 is 0, independent of interrupt enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_event_ff <= 1'b0;
        end else begin
            dma_event_ff <= word_done & ~dma_req_ctrl_ff;
        end
    end

    // Read data captured in the setup cycle, so it is stable for the access edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= ars_pkg::REG_RESET;
        end else if (setup_phase && !pwrite) begin
            if (hit(paddr, ars_pkg::OFS_STATUS)) begin
                prdata_ff <= status_word;
            end else if (hit(paddr, ars_pkg::OFS_SLOT_COUNT)) begin
                prdata_ff <= slot_word;
            end else if (hit(paddr, ars_pkg::OFS_EVENT_CTRL)) begin
                prdata_ff <= {31'h0000_0000, dma_req_ctrl_ff};
            end else if (hit(paddr, ars_pkg::OFS_BUFFER)) begin
                prdata_ff <= {16'h0000, rx_buffer_ff};
            end else if (hit(paddr, ars_pkg::OFS_INT_ENABLE)) begin
                prdata_ff <= {24'h00_0000, int_enable_ff};
            end else begin
                prdata_ff <= ars_pkg::REG_RESET;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    // Level stays high while an enabled flag survives a racing clear
    assign rx_interrupt = |(flags & int_enable_ff & ars_pkg::FLAG_MASK);
    assign rx_dma_event = dma_event_ff;
endmodule

/* File: rtl/ars_sticky.sv */
// Purpose: Bank of sticky flags set by hardware events and cleared by software.
// Assumes: set and clr are one-cycle pulses in the clk_sys domain.
// Notes: A set in the same cycle as a clear keeps the flag.
`timescale 1ns/1ns
module ars_sticky #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] flag_ff;
    logic [W-1:0] nxt_flag;

    // Set term is ORed last so it overrides the clear
    assign nxt_flag = (flag_ff & ~clr) | set;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign q = flag_ff;
endmodule
